// ===== src/sbi_pkg.sv
// sideband io package: register map, nibble codes, bus carrier
// assumes an 8-bit register space shared by local and remote masters
package sbi_pkg;
  // register offsets
  localparam logic [7:0] SBI_GEN_STS = 8'h0c;
  localparam logic [7:0] SBI_LPIN0_CFG = 8'h0d;
  localparam logic [7:0] SBI_LPIN12_CFG = 8'h0e;
  localparam logic [7:0] SBI_LPIN3_CFG = 8'h0f;
  localparam logic [7:0] SBI_RPIN56_CFG = 8'h10;
  localparam logic [7:0] SBI_RPIN78_CFG = 8'h11;
  localparam logic [7:0] SBI_PIN_IN_LO = 8'h1c;
  localparam logic [7:0] SBI_PIN_IN_HI = 8'h1d;
  localparam logic [7:0] SBI_FAR_IRQ_ROUTE = 8'h30;
  localparam logic [7:0] SBI_IRQ_CTRL = 8'hc6;
  localparam logic [7:0] SBI_IRQ_STS = 8'hc7;
  // reset values
  localparam logic [7:0] SBI_CFG_RST = 8'h00;
  localparam logic [7:0] SBI_IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] SBI_ROUTE_RST = 8'h00;
  // configuration nibble codes
  localparam logic [3:0] SBI_NIB_FWD = 4'h3;
  localparam logic [3:0] SBI_NIB_BC = 4'h5;
  localparam logic [3:0] SBI_NIB_OUT_LO = 4'h1;
  localparam logic [3:0] SBI_NIB_OUT_HI = 4'h9;
  localparam logic [3:0] SBI_NIB_IN = 4'h3;
  // field positions
  localparam int SBI_LINK_DET_BIT = 0;
  localparam int SBI_IRQ_EN_BIT = 0;
  localparam int SBI_IRQ_LOC_BIT = 1;
  localparam int SBI_IRQ_REM_BIT = 5;
  localparam int SBI_PIN8_IN_BIT = 0;
  // far interrupt routing select codes
  localparam logic [3:0] SBI_ROUTE_SPLIT = 4'h1;
  // back channel speed modes
  localparam logic [2:0] SBI_BC_NORMAL = 3'b000;
  localparam logic [2:0] SBI_BC_FAST1 = 3'b001;
  localparam logic [2:0] SBI_BC_FAST2 = 3'b010;
  localparam logic [2:0] SBI_BC_FAST4 = 3'b011;
  // power down hold time, enforced by the controlling party
  localparam int SBI_PDN_MIN_US = 2000;
  localparam int SBI_CLK_MHZ = 40;
  localparam int SBI_PDN_MIN_CYC = SBI_PDN_MIN_US * SBI_CLK_MHZ;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sbi_req_t;
endpackage

// ===== src/sbi_sideband_io.sv
// sideband io: link pins, register-only pins, link detect, interrupts
// assumes pins are asynchronous, back channel signals share i_ref_clk
//
// Operation
// - nibble 3 forwards pin, 5 drives back-channel
// - link pin nibbles at 0d, 0e, 0f
// - nibble 1 low, 9 high, 3 input
// - register pins at 10/11, read 1c/1d
// - link pin inputs read at 1c[3:0]
// - enabled register pin overrides audio input
// - local and remote register access both work
// - register pins never sent over link
// - back-channel pins follow remote speed mode
// - interrupt output low on enabled condition
// - far interrupt falling edge pulls output low
// - status read clears pending, releases output
// - passthru pin follows far input when linked
// - dual mode one source, else either
// - route select 1 splits port 0/1
// - routing register copies far irq to pins
// - link detect reads 0 on fault/no cable
// - faults reported only by link detect
// - power-down low resets all registers
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module sbi_sideband_io (
  // clock and power-down reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // local and remote register ports
  input wire sbi_pkg::sbi_req_t i_loc_req,
  output logic [7:0] o_loc_rdata,
  input wire sbi_pkg::sbi_req_t i_rem_req,
  output logic [7:0] o_rem_rdata,
  // link pins 0..3
  input wire logic [3:0] i_lpin,
  output logic [3:0] o_lpin,
  output logic [3:0] o_lpin_oe,
  // register-only pins 5..8
  input wire logic [3:0] i_rpin,
  output logic [3:0] o_rpin,
  output logic [3:0] o_rpin_oe,
  output logic [3:0] o_audio_override,
  // forward and back channel pin values
  output logic [3:0] o_fwd_gpio,
  output logic [3:0] o_fwd_gpio_en,
  input wire logic [3:0] i_bc_gpio,
  input wire logic i_bc_valid,
  input wire logic [2:0] i_control_channel_speed_mode,
  // link state
  input wire logic i_link_ok,
  input wire logic i_cable_fault,
  input wire logic i_dual_mode,
  // interrupt sources and outputs
  input wire logic i_local_evt,
  input wire logic [1:0] i_far_irq_in_n,
  output logic o_irq_out_n,
  output logic o_far_irq_passthru_n,
  output logic [3:0] o_far_irq_copy_n
);
  import sbi_pkg::*;

  // registers
  logic [7:0] cfg_d_r, cfg_e_r, cfg_f_r, cfg_10_r, cfg_11_r;
  logic [7:0] irq_ctrl_r, route_r;
  logic loc_pend_r, rem_pend_r;
  logic [7:0] loc_rdata_r, rem_rdata_r;
  logic [3:0] lpin_s1_r, lpin_s2_r, rpin_s1_r, rpin_s2_r;
  logic [1:0] link_s1_r, link_s2_r;
  logic [3:0] bc_val_r;
  logic rem_src_d_r;
  logic [3:0] lpin_r, lpin_oe_r, rpin_r, rpin_oe_r, ovr_r;
  logic [3:0] fwd_r, fwd_en_r, copy_r;
  logic irq_r, pass_r;

  // write select, local wins a same-cycle collision
  function automatic logic [7:0] wsel(input sbi_req_t l, input sbi_req_t r,
                                      input logic [7:0] a, input logic [7:0] cur);
    logic [7:0] v;
    v = cur;
    if (r.wr && r.addr == a) begin
      v = r.wdata;
    end
    if (l.wr && l.addr == a) begin
      v = l.wdata;
    end
    return v;
  endfunction

  // register next values, either port writes
  wire [7:0] cfg_d_nxt = wsel(i_loc_req, i_rem_req, SBI_LPIN0_CFG, cfg_d_r);
  wire [7:0] cfg_e_nxt = wsel(i_loc_req, i_rem_req, SBI_LPIN12_CFG, cfg_e_r);
  wire [7:0] cfg_f_nxt = wsel(i_loc_req, i_rem_req, SBI_LPIN3_CFG, cfg_f_r);
  wire [7:0] cfg_10_nxt = wsel(i_loc_req, i_rem_req, SBI_RPIN56_CFG, cfg_10_r);
  wire [7:0] cfg_11_nxt = wsel(i_loc_req, i_rem_req, SBI_RPIN78_CFG, cfg_11_r);
  wire [7:0] irq_ctrl_nxt = wsel(i_loc_req, i_rem_req, SBI_IRQ_CTRL, irq_ctrl_r);
  wire [7:0] route_nxt = wsel(i_loc_req, i_rem_req, SBI_FAR_IRQ_ROUTE, route_r);

  // per-pin nibbles: 0..3 link pins, 4..7 register pins 5..8
  wire [3:0] nib [8];
  assign nib[0] = cfg_d_r[3:0];
  assign nib[1] = cfg_e_r[3:0];
  assign nib[2] = cfg_e_r[7:4];
  assign nib[3] = cfg_f_r[3:0];
  assign nib[4] = cfg_10_r[3:0];
  assign nib[5] = cfg_10_r[7:4];
  assign nib[6] = cfg_11_r[3:0];
  assign nib[7] = cfg_11_r[7:4];

  // pins allowed by the back-channel speed mode
  logic [3:0] bc_allow;
  always_comb begin
    case (i_control_channel_speed_mode)
      SBI_BC_NORMAL: bc_allow = 4'hf;
      SBI_BC_FAST4: bc_allow = 4'hf;
      SBI_BC_FAST2: bc_allow = 4'h3;
      SBI_BC_FAST1: bc_allow = 4'h1;
      default: bc_allow = 4'h0;
    endcase
  end

  // per-pin decode
  wire [7:0] pin_in = {rpin_s2_r, lpin_s2_r};
  wire [7:0] drv_en, drv_val, is_in;
  wire [3:0] is_fwd, is_bc, bc_nxt;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      wire lo = (nib[g] == SBI_NIB_OUT_LO);
      wire hi = (nib[g] == SBI_NIB_OUT_HI);
      assign is_in[g] = (nib[g] == SBI_NIB_IN);
      if (g < 4) begin : g_link
        assign is_fwd[g] = (nib[g] == SBI_NIB_FWD);
        assign is_bc[g] = (nib[g] == SBI_NIB_BC);
        assign bc_nxt[g] = (i_bc_valid && bc_allow[g]) ? i_bc_gpio[g] : bc_val_r[g];
        assign drv_en[g] = lo | hi | is_bc[g];
        assign drv_val[g] = hi | (is_bc[g] & bc_val_r[g]);
      end else begin : g_reg
        assign drv_en[g] = lo | hi;
        assign drv_val[g] = hi;
      end
    end
  endgenerate

  // input status bytes, bit 4 of the low byte reads zero
  wire [7:0] in_lo = {pin_in[6:4] & is_in[6:4], 1'b0,
                      pin_in[3:0] & is_in[3:0]};
  wire [7:0] in_hi = {7'h00, pin_in[7] & is_in[7]};
  wire link_det = link_s2_r[0] & ~link_s2_r[1];
  wire [7:0] gen_sts = {7'h00, link_det};
  wire [7:0] irq_sts = {2'b00, rem_pend_r, 3'b000, loc_pend_r, loc_pend_r | rem_pend_r};

  // read mux shared by both ports
  function automatic logic [7:0] rmux(input logic [7:0] a, input logic [7:0] gs,
                                      input logic [7:0] lo, input logic [7:0] hi,
                                      input logic [7:0] is);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      SBI_GEN_STS: v = gs;
      SBI_LPIN0_CFG: v = cfg_d_r;
      SBI_LPIN12_CFG: v = cfg_e_r;
      SBI_LPIN3_CFG: v = cfg_f_r;
      SBI_RPIN56_CFG: v = cfg_10_r;
      SBI_RPIN78_CFG: v = cfg_11_r;
      SBI_PIN_IN_LO: v = lo;
      SBI_PIN_IN_HI: v = hi;
      SBI_FAR_IRQ_ROUTE: v = route_r;
      SBI_IRQ_CTRL: v = irq_ctrl_r;
      SBI_IRQ_STS: v = is;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  wire [7:0] loc_rdata_nxt = i_loc_req.rd ? rmux(i_loc_req.addr, gen_sts, in_lo, in_hi,
                                                  irq_sts) : 8'h00;
  wire [7:0] rem_rdata_nxt = i_rem_req.rd ? rmux(i_rem_req.addr, gen_sts, in_lo, in_hi,
                                                  irq_sts) : 8'h00;

  // far interrupt source selection, active low
  wire far_any_n = i_dual_mode ? i_far_irq_in_n[0] : &i_far_irq_in_n;
  wire split = (route_r[3:0] == SBI_ROUTE_SPLIT);
  wire pass_nxt = ~link_det | (split ? i_far_irq_in_n[0] : far_any_n);
  wire rem_src_n = split ? i_far_irq_in_n[1] : far_any_n;
  wire rem_fall = rem_src_d_r & ~rem_src_n;
  wire rem_en = irq_ctrl_r[SBI_IRQ_EN_BIT] & irq_ctrl_r[SBI_IRQ_REM_BIT];
  wire loc_en = irq_ctrl_r[SBI_IRQ_EN_BIT] & irq_ctrl_r[SBI_IRQ_LOC_BIT];
  wire sts_rd = (i_loc_req.rd && i_loc_req.addr == SBI_IRQ_STS) ||
                (i_rem_req.rd && i_rem_req.addr == SBI_IRQ_STS);
  // set wins over the read clear
  wire rem_pend_nxt = (rem_en & rem_fall) | (rem_pend_r & ~sts_rd);
  wire loc_pend_nxt = (loc_en & i_local_evt) | (loc_pend_r & ~sts_rd);
  wire irq_nxt = ~((rem_pend_nxt & rem_en) | (loc_pend_nxt & loc_en));
  wire [3:0] copy_nxt = ~(route_r[7:4] & {4{~pass_nxt}});

  // link pin 0 configuration, cleared by power-down
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_d_r <= SBI_CFG_RST;
    end else begin
      cfg_d_r <= cfg_d_nxt;
    end
  end

  // link pins 1 and 2 configuration
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_e_r <= SBI_CFG_RST;
    end else begin
      cfg_e_r <= cfg_e_nxt;
    end
  end

  // link pin 3 configuration
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_f_r <= SBI_CFG_RST;
    end else begin
      cfg_f_r <= cfg_f_nxt;
    end
  end

  // register pins 5 and 6 configuration
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_10_r <= SBI_CFG_RST;
    end else begin
      cfg_10_r <= cfg_10_nxt;
    end
  end

  // register pins 7 and 8 configuration
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_11_r <= SBI_CFG_RST;
    end else begin
      cfg_11_r <= cfg_11_nxt;
    end
  end

  // interrupt control, enables start cleared
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_ctrl_r <= SBI_IRQ_CTRL_RST;
    end else begin
      irq_ctrl_r <= irq_ctrl_nxt;
    end
  end

  // far interrupt routing and copy enables
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      route_r <= SBI_ROUTE_RST;
    end else begin
      route_r <= route_nxt;
    end
  end

  // two-stage synchronisers for the pin inputs
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lpin_s1_r <= 4'h0;
      lpin_s2_r <= 4'h0;
      rpin_s1_r <= 4'h0;
      rpin_s2_r <= 4'h0;
    end else begin
      lpin_s1_r <= i_lpin;
      lpin_s2_r <= lpin_s1_r;
      rpin_s1_r <= i_rpin;
      rpin_s2_r <= rpin_s1_r;
    end
  end

  // link state synchroniser, a glitch here would fake a link
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link_s1_r <= 2'b00;
      link_s2_r <= 2'b00;
    end else begin
      link_s1_r <= {i_cable_fault, i_link_ok};
      link_s2_r <= link_s1_r;
    end
  end

  // pending flags, set wins over the read clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loc_pend_r <= 1'b0;
      rem_pend_r <= 1'b0;
    end else begin
      loc_pend_r <= loc_pend_nxt;
      rem_pend_r <= rem_pend_nxt;
    end
  end

  // far source history, idles high so reset gives no false edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rem_src_d_r <= 1'b1;
    end else begin
      rem_src_d_r <= rem_src_n;
    end
  end

  // interrupt, passthrough and copy outputs, all idle high
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_r <= 1'b1;
      pass_r <= 1'b1;
      copy_r <= 4'hf;
    end else begin
      irq_r <= irq_nxt;
      pass_r <= pass_nxt;
      copy_r <= copy_nxt;
    end
  end

  // read data, zero outside the cycle after a read
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loc_rdata_r <= 8'h00;
      rem_rdata_r <= 8'h00;
    end else begin
      loc_rdata_r <= loc_rdata_nxt;
      rem_rdata_r <= rem_rdata_nxt;
    end
  end

  // back-channel sample hold between valid slots
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bc_val_r <= 4'h0;
    end else begin
      bc_val_r <= bc_nxt;
    end
  end

  // link pin drivers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lpin_r <= 4'h0;
      lpin_oe_r <= 4'h0;
    end else begin
      lpin_r <= drv_val[3:0];
      lpin_oe_r <= drv_en[3:0];
    end
  end

  // register pin drivers and audio override
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rpin_r <= 4'h0;
      rpin_oe_r <= 4'h0;
      ovr_r <= 4'h0;
    end else begin
      rpin_r <= drv_val[7:4];
      rpin_oe_r <= drv_en[7:4];
      ovr_r <= drv_en[7:4] | is_in[7:4];
    end
  end

  // forward channel values, link pins only
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fwd_r <= 4'h0;
      fwd_en_r <= 4'h0;
    end else begin
      fwd_r <= lpin_s2_r & is_fwd;
      fwd_en_r <= is_fwd;
    end
  end

  // outputs
  assign o_loc_rdata = loc_rdata_r;
  assign o_rem_rdata = rem_rdata_r;
  assign o_lpin = lpin_r;
  assign o_lpin_oe = lpin_oe_r;
  assign o_rpin = rpin_r;
  assign o_rpin_oe = rpin_oe_r;
  assign o_audio_override = ovr_r;
  assign o_fwd_gpio = fwd_r;
  assign o_fwd_gpio_en = fwd_en_r;
  assign o_irq_out_n = irq_r;
  assign o_far_irq_passthru_n = pass_r;
  assign o_far_irq_copy_n = copy_r;
endmodule
`default_nettype wire

// ===== testbench/sbi_sideband_io_sva.sv
// checker for the sideband io block
// assumes it sees only the top ports, bound at the foot
`timescale 1ns/100ps
`default_nettype none
module sbi_sideband_io_sva (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register ports
  input wire sbi_pkg::sbi_req_t i_loc_req,
  input wire sbi_pkg::sbi_req_t i_rem_req,
  input wire logic [7:0] o_loc_rdata,
  input wire logic [7:0] o_rem_rdata,
  // pins, link and interrupts
  input wire logic [3:0] o_rpin,
  input wire logic [3:0] o_rpin_oe,
  input wire logic i_link_ok,
  input wire logic i_cable_fault,
  input wire logic i_local_evt,
  input wire logic [1:0] i_far_irq_in_n,
  input wire logic o_irq_out_n,
  input wire logic o_far_irq_passthru_n
);
  import sbi_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // decoded requests and link state
  wire lnk = i_link_ok && !i_cable_fault;
  wire w10 = i_loc_req.wr && i_loc_req.addr == SBI_RPIN56_CFG;
  wire rd7 = i_loc_req.rd && i_loc_req.addr == SBI_IRQ_STS;
  property p_loc_idle; !$past(i_loc_req.rd) |-> o_loc_rdata == 8'h00; endproperty
  a_loc_idle: assert property (p_loc_idle)
    else $error("local read data not idle");
  property p_rem_idle; !$past(i_rem_req.rd) |-> o_rem_rdata == 8'h00; endproperty
  a_rem_idle: assert property (p_rem_idle)
    else $error("remote read data not idle");
  property p_pin5_hi;
    w10 && i_loc_req.wdata[3:0] == SBI_NIB_OUT_HI |-> ##2 o_rpin[0] && o_rpin_oe[0];
  endproperty
  a_pin5_hi: assert property (p_pin5_hi)
    else $error("pin 5 not driven high");
  property p_pin5_lo;
    w10 && i_loc_req.wdata[3:0] == SBI_NIB_OUT_LO |-> ##2 !o_rpin[0] && o_rpin_oe[0];
  endproperty
  a_pin5_lo: assert property (p_pin5_lo)
    else $error("pin 5 not driven low");
  property p_irq_rel;
    rd7 && i_far_irq_in_n == 2'b11 && $past(i_far_irq_in_n) == 2'b11 && !i_local_evt
      && !$past(i_local_evt) |=> o_irq_out_n;
  endproperty
  a_irq_rel: assert property (p_irq_rel)
    else $error("status read kept interrupt low");
  property p_pass_low; (lnk && i_far_irq_in_n == 2'b00)[*4] |=> !o_far_irq_passthru_n; endproperty
  a_pass_low: assert property (p_pass_low)
    else $error("passthrough not asserted");
  property p_pass_nolink; (!lnk)[*4] |=> o_far_irq_passthru_n; endproperty
  a_pass_nolink: assert property (p_pass_nolink)
    else $error("passthrough active without link");
  property p_link_det;
    (!lnk)[*4] ##0 (i_loc_req.rd && i_loc_req.addr == SBI_GEN_STS) |=> !o_loc_rdata[0];
  endproperty
  a_link_det: assert property (p_link_det)
    else $error("link detect set on fault");
endmodule
bind sbi_sideband_io sbi_sideband_io_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_loc_req(i_loc_req), .i_rem_req(i_rem_req), .o_loc_rdata(o_loc_rdata),
  .o_rem_rdata(o_rem_rdata), .o_rpin(o_rpin), .o_rpin_oe(o_rpin_oe), .i_link_ok(i_link_ok),
  .i_cable_fault(i_cable_fault), .i_local_evt(i_local_evt), .i_far_irq_in_n(i_far_irq_in_n),
  .o_irq_out_n(o_irq_out_n), .o_far_irq_passthru_n(o_far_irq_passthru_n));
`default_nettype wire

// ===== testbench/sbi_far_model.sv
// far deserializer stand-in: back-channel frames and interrupt lines
// assumes the bench sets mode, pin values and interrupt levels
`timescale 1ns/100ps
`default_nettype none
module sbi_far_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // wanted values
  input wire logic [2:0] i_mode,
  input wire logic [3:0] i_gpio,
  input wire logic [1:0] i_irq_n,
  // towards the serializer
  output logic [3:0] o_bc_gpio,
  output logic o_bc_valid,
  output logic [2:0] o_mode,
  output logic [1:0] o_irq_n
);
  logic [1:0] cnt_r;
  // frame timer, one sample every fourth clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_r <= 2'h0;
    else cnt_r <= cnt_r + 2'h1;
  end
  // sample valid only in its frame slot, inverse otherwise
  assign o_bc_valid = i_rst_n && cnt_r == 2'h3;
  assign o_bc_gpio = o_bc_valid ? i_gpio : ~i_gpio;
  assign o_mode = i_mode;
  assign o_irq_n = i_irq_n;
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// bench for the sideband io block
// assumes the far model and one 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sbi_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, evt = 1'b0, lok = 1'b1, flt = 1'b0, bv, iq, pt;
  logic dm = 1'b0;
  logic [3:0] lpin = '0, rpin = '0, gp = '0, lo, loe, ro, roe, aud, fg, fge, bg, cp;
  logic [2:0] md = '0, bm;
  logic [1:0] irq = 2'b11, fi;
  logic [7:0] lrd, rrd, a;
  sbi_req_t loc = '0, rem = '0;
  int bad_count = 0, compares = 0;
  always #12.5 clk = ~clk;
  // far side and block under test
  sbi_far_model u_sbi_far_model (.i_clk(clk), .i_rst_n(rst_n), .i_mode(md), .i_gpio(gp),
    .i_irq_n(irq), .o_bc_gpio(bg), .o_bc_valid(bv), .o_mode(bm), .o_irq_n(fi));
  sbi_sideband_io u_sbi_sideband_io (.i_ref_clk(clk), .i_rst_n(rst_n), .i_loc_req(loc),
    .o_loc_rdata(lrd), .i_rem_req(rem), .o_rem_rdata(rrd), .i_lpin(lpin), .o_lpin(lo),
    .o_lpin_oe(loe), .i_rpin(rpin), .o_rpin(ro), .o_rpin_oe(roe), .o_audio_override(aud),
    .o_fwd_gpio(fg), .o_fwd_gpio_en(fge), .i_bc_gpio(bg), .i_bc_valid(bv),
    .i_control_channel_speed_mode(bm), .i_link_ok(lok), .i_cable_fault(flt),
    .i_dual_mode(dm), .i_local_evt(evt), .i_far_irq_in_n(fi), .o_irq_out_n(iq),
    .o_far_irq_passthru_n(pt), .o_far_irq_copy_n(cp));
  task automatic finish_test();
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // masked compare of one result byte
  task automatic chk(input logic [7:0] g, m, e);
    compares++;
    if ((g & m) !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g & m, e);
    end
  endtask
  task automatic ciq(input logic v);
    chk({7'h0, iq}, 8'h01, {7'h0, v});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one register access on the local or remote port
  task automatic bus(input bit r, w, input logic [7:0] ad, d);
    sbi_req_t q;
    q = '{ad, d, w, !w};
    @(posedge clk);
    if (r) rem <= q;
    else loc <= q;
    @(posedge clk);
    loc <= '0;
    rem <= '0;
  endtask
  task automatic rd(input bit r, input logic [7:0] ad, m, e);
    bus(r, 1'b0, ad, 8'h00);
    #1 chk(r ? rrd : lrd, m, e);
  endtask
  task automatic far(input logic [1:0] v);
    @(posedge clk);
    irq <= v;
    cyc(5);
  endtask
  // defaults and an unmapped place
  task automatic t_dflt();
    logic [7:0] ra [7] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h30, 8'hc6};
    bus(1'b0, 1'b1, 8'h55, 8'hff);
    rd(1'b1, 8'h55, 8'hff, 8'h00);
    foreach (ra[k]) rd(k[0], ra[k], 8'hff, 8'h00);
    chk({loe, roe}, 8'hff, 8'h00);
    ciq(1'b1);
  endtask
  // link pins through every nibble code
  task automatic t_lpin();
    logic [3:0] nb [4] = '{4'h9, 4'h3, 4'h1, 4'h5};
    logic [7:0] nm [4] = '{8'h0e, 8'h07, 8'h0e, 8'h0e};
    logic [7:0] ne [4] = '{8'h0c, 8'h03, 8'h04, 8'h0c};
    for (int i = 0; i < 4; i++) begin
      a = i == 0 ? SBI_LPIN0_CFG : i == 3 ? SBI_LPIN3_CFG : SBI_LPIN12_CFG;
      foreach (nb[c]) begin
        @(posedge clk);
        lpin <= 4'h1 << i;
        gp <= 4'h1 << i;
        bus(i[0], 1'b1, a, {4'h0, nb[c]} << (i == 2 ? 4 : 0));
        cyc(8);
        chk({lo[i], loe[i], fge[i], fg[i]}, nm[c], ne[c]);
        if (c == 1) rd(1'b0, SBI_PIN_IN_LO, 8'h1 << i, 8'h1 << i);
      end
    end
  endtask
  // back-channel pin 1 under each speed mode
  task automatic t_speed();
    logic [2:0] sm [4] = '{SBI_BC_NORMAL, SBI_BC_FAST1, SBI_BC_FAST2, SBI_BC_FAST4};
    bus(1'b0, 1'b1, SBI_LPIN12_CFG, 8'h05);
    foreach (sm[k]) begin
      @(posedge clk);
      md <= sm[k];
      gp <= k == 1 || k == 2 ? 4'h2 : 4'h0;
      cyc(12);
      chk({7'h0, lo[1]}, 8'h01, {7'h0, k == 2});
    end
  endtask
  // register-only pins, half of them from the remote port
  task automatic t_rpin();
    logic [3:0] rn [3] = '{4'h9, 4'h1, 4'h3};
    logic [7:0] re [3] = '{8'h0e, 8'h06, 8'h02};
    for (int j = 0; j < 4; j++) begin
      a = j < 2 ? SBI_RPIN56_CFG : SBI_RPIN78_CFG;
      foreach (rn[c]) begin
        @(posedge clk);
        rpin <= 4'h1 << j;
        bus(j[0], 1'b1, a, {4'h0, rn[c]} << (j[0] ? 4 : 0));
        cyc(4);
        chk({ro[j], roe[j], aud[j], |fge}, c == 2 ? 8'h07 : 8'h0f, re[c]);
      end
      a = j == 3 ? 8'h01 : 8'h20 << j;
      rd(j[0], j == 3 ? SBI_PIN_IN_HI : SBI_PIN_IN_LO, a, a);
    end
  endtask
  // far and local interrupts, enable, clear, re-arm
  task automatic t_irq();
    bus(1'b0, 1'b1, SBI_IRQ_CTRL, 8'h01);
    far(2'b10);
    ciq(1'b1);
    far(2'b11);
    bus(1'b0, 1'b1, SBI_IRQ_CTRL, 8'h21);
    far(2'b10);
    ciq(1'b0);
    rd(1'b1, SBI_IRQ_STS, 8'h21, 8'h21);
    ciq(1'b1);
    cyc(5);
    ciq(1'b1);
    far(2'b11);
    far(2'b10);
    ciq(1'b0);
    far(2'b11);
    rd(1'b0, SBI_IRQ_STS, 8'h21, 8'h21);
    ciq(1'b1);
    bus(1'b0, 1'b1, SBI_IRQ_CTRL, 8'h03);
    @(posedge clk);
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
    cyc(2);
    ciq(1'b0);
    rd(1'b0, SBI_IRQ_STS, 8'h02, 8'h02);
  endtask
  // passthrough, split routing, copies, link detect
  task automatic t_pass();
    logic [1:0] lk [3] = '{2'b10, 2'b11, 2'b00};
    bus(1'b0, 1'b1, SBI_IRQ_CTRL, 8'h21);
    far(2'b01);
    chk({7'h0, pt}, 8'h01, 8'h00);
    @(posedge clk);
    dm <= 1'b1;
    cyc(4);
    chk({7'h0, pt}, 8'h01, 8'h01);
    @(posedge clk);
    dm <= 1'b0;
    far(2'b00);
    far(2'b11);
    bus(1'b0, 1'b1, SBI_FAR_IRQ_ROUTE, 8'h11);
    rd(1'b0, SBI_IRQ_STS, 8'hff, 8'h21);
    far(2'b01);
    chk({pt, iq, cp}, 8'h3f, 8'h2f);
    rd(1'b0, SBI_IRQ_STS, 8'h20, 8'h20);
    far(2'b10);
    chk({pt, iq, cp}, 8'h3f, 8'h1e);
    foreach (lk[k]) begin
      @(posedge clk);
      lok <= lk[k][1];
      flt <= lk[k][0];
      cyc(6);
      rd(1'b0, SBI_GEN_STS, 8'h01, {7'h0, k == 0});
      chk({7'h0, pt}, 8'h01, {7'h0, k != 0});
    end
  endtask
  // power-down in mid-run
  task automatic t_rst();
    bus(1'b0, 1'b1, SBI_RPIN56_CFG, 8'h99);
    cyc(3);
    chk({4'h0, roe}, 8'h03, 8'h03);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    chk({4'h0, roe}, 8'h0f, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    t_dflt();
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_dflt();
    t_lpin();
    t_speed();
    t_rpin();
    t_irq();
    t_pass();
    t_rst();
    finish_test();
  end
endmodule
`default_nettype wire
